/* design/rss_map.svh */
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// register byte offsets, compared against haddr[11:0]; the file base is compared against haddr[11:9]
`define RSS_OFF_INSTR 12'h000
`define RSS_OFF_WORK 12'h004
`define RSS_OFF_STATUS 12'h008
`define RSS_OFF_WDOG 12'h00C
`define RSS_OFF_RESULT 12'h010
`define RSS_OFF_COUNT 12'h014
`define RSS_FILE_BASE_HI 3'h1

// instruction word fields
`define RSS_INSTR_OP_LSB 0
`define RSS_INSTR_DEST_BIT 2
`define RSS_INSTR_FADDR_LSB 8
`define RSS_INSTR_LIT_LSB 16

// status word fields
`define RSS_ST_CARRY 0
`define RSS_ST_DC 1
`define RSS_ST_ZERO 2
`define RSS_ST_TO_N 3
`define RSS_ST_PD_N 4
`define RSS_ST_BUSY 5
`define RSS_ST_SLEEP 6

// reset values
`define RSS_RST_WORK 8'h00
`define RSS_RST_TO_N 1'b1
`define RSS_RST_PD_N 1'b1
`define RSS_RST_FLAGS 3'h0

// watchdog timing
`define RSS_WDOG_PRE_W 8
`define RSS_WDOG_CNT_W 8

`endif

/* design/rss_pkg.sv */
package rss_pkg;

    typedef enum logic [1:0] {
        rotate_right_carry_op = 2'h0,
        literal_minus_work_op = 2'h1,
        file_minus_work_op = 2'h2,
        sleep_op = 2'h3
    } rss_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_SLEEP = 3'b100
    } rss_state_t;

    typedef struct packed {
        logic [7:0] literal;
        logic [6:0] faddr;
        logic dest;
        rss_op_t op;
    } rss_instr_t;

    typedef struct packed {
        logic [7:0] value;
        logic carry;
        logic digit_carry_flag;
        logic zero;
        logic write_dcz;
    } rss_alu_res_t;

endpackage

/* design/rss_alu.sv */
`timescale 1ns/100ps

module rss_alu (
    input wire rss_pkg::rss_op_t op, // operation being executed
    input wire logic [7:0] file_val, // addressed file register
    input wire logic [7:0] work, // working register
    input wire logic [7:0] literal, // immediate operand
    input wire logic carry_in, // current carry flag
    output rss_pkg::rss_alu_res_t res // value and flags
);
    logic [7:0] minuend;
    logic [8:0] diff;
    logic [4:0] dlow;

    always_comb begin
        minuend = (op == rss_pkg::literal_minus_work_op) ? literal : file_val;
        // two's complement: a + ~w + 1, carry out means no borrow
        diff = {1'b0, minuend} + {1'b0, ~work} + 9'h001; // [RULE3] [RULE5]
        dlow = {1'b0, minuend[3:0]} + {1'b0, ~work[3:0]} + 5'h01;
        res.value = file_val;
        res.carry = carry_in;
        res.digit_carry_flag = 1'b0;
        res.zero = 1'b0;
        res.write_dcz = 1'b0;
        case (op)
            rss_pkg::rotate_right_carry_op: begin
                res.value = {carry_in, file_val[7:1]}; // [RULE1]
                res.carry = file_val[0]; // [RULE1]
            end
            rss_pkg::literal_minus_work_op,
            rss_pkg::file_minus_work_op: begin
                res.value = diff[7:0];
                res.carry = diff[8]; // [RULE10]
                res.digit_carry_flag = dlow[4]; // [RULE10]
                res.zero = (diff[7:0] == 8'h00); // [RULE10]
                res.write_dcz = 1'b1;
            end
            default: begin
                res.value = file_val;
            end
        endcase
    end

endmodule

/* design/rss_regfile.sv */
`timescale 1ns/100ps

module rss_regfile #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic clk, // core clock
    input wire logic we, // write strobe
    input wire logic [AW-1:0] waddr, // write address
    input wire logic [7:0] wdata, // write data
    input wire logic [AW-1:0] raddr_a, // execution read address
    output logic [7:0] rdata_a, // execution read data
    input wire logic [AW-1:0] raddr_b, // bus read address
    output logic [7:0] rdata_b // bus read data
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

endmodule

/* design/rss_top.sv */
// Overview of operation
// RULE1 - rotate right: old carry into bit 7, old bit 0 into carry
// RULE2 - rotate result goes to work register if dest 0, file register if dest 1
// RULE3 - literal subtract computes 8-bit literal minus work register, two's complement
// RULE4 - literal subtract result always lands in the work register
// RULE5 - file subtract computes file register (address 0..127) minus work register
// RULE6 - file subtract result goes to work if dest 0, file if dest 1
// RULE7 - sleep clears the watchdog counter and its prescaler
// RULE8 - sleep drives power-down status low, time-out status high, nothing else
// RULE9 - after sleep the core halts and the oscillator stops
// RULE10 - subtracts set carry on w<=minuend, digit carry on low nibble, zero on zero
`timescale 1ns/100ps
`include "rss_map.svh"

module rss_top #(
    parameter int PRE_W = `RSS_WDOG_PRE_W,
    parameter int CNT_W = `RSS_WDOG_CNT_W
) (
    input wire logic hclk, // core clock
    input wire logic hresetn, // async reset
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic wake_pin, // wake request from outside
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    output logic core_halt, // core halted in sleep
    output logic osc_stop, // oscillator stop request
    output logic wdt_clear // watchdog clear pulse
);
    rss_pkg::rss_state_t st_r;
    rss_pkg::rss_instr_t instr_r;
    rss_pkg::rss_alu_res_t alu_res;

    logic ph_wr_r;
    logic [11:0] ph_addr_r;
    logic [31:0] rd_nxt;
    logic [7:0] work_r;
    logic carry_r;
    logic dc_r;
    logic zero_r;
    logic timeout_status_n;
    logic powerdown_status_n;
    logic [PRE_W-1:0] wdog_pre_r;
    logic [CNT_W-1:0] watchdog_counter;
    logic [7:0] result_r;
    logic [15:0] count_r;
    logic wake_s1_r;
    logic wake_s2_r;
    logic hreadyout_r;
    logic core_halt_r;
    logic osc_stop_r;
    logic wdt_clear_r;
    logic [7:0] file_rd;
    logic [7:0] bus_file_rd;
    logic file_we;
    logic [6:0] file_waddr;
    logic [7:0] file_wdata;
    logic wr_instr;
    logic wr_work;
    logic wr_status;
    logic wr_wdog;
    logic wr_file;
    logic exec;
    logic exec_sleep;
    logic exec_to_work;
    logic exec_to_file;

    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
    assign core_halt = core_halt_r;
    assign osc_stop = osc_stop_r;
    assign wdt_clear = wdt_clear_r;

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_r <= 1'b0;
            ph_addr_r <= 12'h000;
        end else if (hready) begin
            ph_wr_r <= hsel && htrans[1] && hwrite;
            ph_addr_r <= haddr[11:0];
        end
    end

    // no wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
        end
    end

    // data phase write decode
    always_comb begin
        wr_instr = 1'b0;
        wr_work = 1'b0;
        wr_status = 1'b0;
        wr_wdog = 1'b0;
        wr_file = 1'b0;
        if (!ph_wr_r) begin
            wr_instr = 1'b0;
        end else if (ph_addr_r == `RSS_OFF_INSTR) begin
            wr_instr = 1'b1;
        end else if (ph_addr_r == `RSS_OFF_WORK) begin
            wr_work = 1'b1;
        end else if (ph_addr_r == `RSS_OFF_STATUS) begin
            wr_status = 1'b1;
        end else if (ph_addr_r == `RSS_OFF_WDOG) begin
            wr_wdog = 1'b1;
        end else if (ph_addr_r[11:9] == `RSS_FILE_BASE_HI) begin
            wr_file = 1'b1;
        end
    end

    // read mux, registered during the address phase
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (haddr[11:0] == `RSS_OFF_INSTR) begin
            rd_nxt = {8'h00, instr_r.literal, 1'b0, instr_r.faddr, 5'h00, instr_r.dest,
                      instr_r.op};
        end else if (haddr[11:0] == `RSS_OFF_WORK) begin
            rd_nxt = {24'h00_0000, work_r};
        end else if (haddr[11:0] == `RSS_OFF_STATUS) begin
            rd_nxt[`RSS_ST_CARRY] = carry_r;
            rd_nxt[`RSS_ST_DC] = dc_r;
            rd_nxt[`RSS_ST_ZERO] = zero_r;
            rd_nxt[`RSS_ST_TO_N] = timeout_status_n;
            rd_nxt[`RSS_ST_PD_N] = powerdown_status_n;
            rd_nxt[`RSS_ST_BUSY] = (st_r != rss_pkg::ST_IDLE);
            rd_nxt[`RSS_ST_SLEEP] = (st_r == rss_pkg::ST_SLEEP);
        end else if (haddr[11:0] == `RSS_OFF_WDOG) begin
            rd_nxt[CNT_W-1:0] = watchdog_counter;
            rd_nxt[16 +: PRE_W] = wdog_pre_r;
        end else if (haddr[11:0] == `RSS_OFF_RESULT) begin
            rd_nxt = {24'h00_0000, result_r};
        end else if (haddr[11:0] == `RSS_OFF_COUNT) begin
            rd_nxt = {16'h0000, count_r};
        end else if (haddr[11:9] == `RSS_FILE_BASE_HI) begin
            rd_nxt = {24'h00_0000, bus_file_rd};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rd_nxt;
        end
    end

    // wake pin synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else begin
            wake_s1_r <= wake_pin;
            wake_s2_r <= wake_s1_r;
        end
    end

    // execution sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= rss_pkg::ST_IDLE;
        end else begin
            case (st_r)
                rss_pkg::ST_IDLE: begin
                    if (wr_instr) begin
                        st_r <= rss_pkg::ST_EXEC;
                    end
                end
                rss_pkg::ST_EXEC: begin
                    if (instr_r.op == rss_pkg::sleep_op) begin
                        st_r <= rss_pkg::ST_SLEEP; // [RULE9]
                    end else begin
                        st_r <= rss_pkg::ST_IDLE;
                    end
                end
                rss_pkg::ST_SLEEP: begin
                    if (wake_s2_r) begin
                        st_r <= rss_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_r <= rss_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // instructions written while busy are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_r <= '0;
        end else if (wr_instr && st_r == rss_pkg::ST_IDLE) begin
            instr_r.op <= rss_pkg::rss_op_t'(hwdata[`RSS_INSTR_OP_LSB +: 2]);
            instr_r.dest <= hwdata[`RSS_INSTR_DEST_BIT];
            instr_r.faddr <= hwdata[`RSS_INSTR_FADDR_LSB +: 7]; // [RULE5]
            instr_r.literal <= hwdata[`RSS_INSTR_LIT_LSB +: 8]; // [RULE3]
        end
    end

    assign exec = (st_r == rss_pkg::ST_EXEC);
    assign exec_sleep = exec && (instr_r.op == rss_pkg::sleep_op);
    assign exec_to_work = exec // [RULE2] [RULE4] [RULE6]
                          && (instr_r.op == rss_pkg::literal_minus_work_op
                          || (instr_r.op != rss_pkg::sleep_op && !instr_r.dest));
    assign exec_to_file = exec && instr_r.dest
                          && (instr_r.op == rss_pkg::rotate_right_carry_op
                          || instr_r.op == rss_pkg::file_minus_work_op); // [RULE2] [RULE6]

    rss_alu u_alu (
        .op(instr_r.op),
        .file_val(file_rd),
        .work(work_r),
        .literal(instr_r.literal),
        .carry_in(carry_r),
        .res(alu_res)
    );

    // execution write-back has priority over a bus write
    assign file_we = exec_to_file || wr_file;
    assign file_waddr = exec_to_file ? instr_r.faddr : ph_addr_r[8:2];
    assign file_wdata = exec_to_file ? alu_res.value : hwdata[7:0];

    rss_regfile #(
        .DEPTH(128),
        .AW(7)
    ) u_file (
        .clk(hclk),
        .we(file_we),
        .waddr(file_waddr),
        .wdata(file_wdata),
        .raddr_a(instr_r.faddr),
        .rdata_a(file_rd),
        .raddr_b(haddr[8:2]),
        .rdata_b(bus_file_rd)
    );

    // working register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            work_r <= `RSS_RST_WORK;
        end else if (exec_to_work) begin
            work_r <= alu_res.value; // [RULE2] [RULE4] [RULE6]
        end else if (wr_work) begin
            work_r <= hwdata[7:0];
        end
    end

    // arithmetic flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {zero_r, dc_r, carry_r} <= `RSS_RST_FLAGS;
        end else if (exec && !exec_sleep) begin
            carry_r <= alu_res.carry; // [RULE1] [RULE10]
            if (alu_res.write_dcz) begin
                dc_r <= alu_res.digit_carry_flag; // [RULE10]
                zero_r <= alu_res.zero; // [RULE10]
            end
        end else if (wr_status) begin
            carry_r <= hwdata[`RSS_ST_CARRY];
            dc_r <= hwdata[`RSS_ST_DC];
            zero_r <= hwdata[`RSS_ST_ZERO];
        end
    end

    // power status bits, only sleep touches them here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timeout_status_n <= `RSS_RST_TO_N;
            powerdown_status_n <= `RSS_RST_PD_N;
        end else if (exec_sleep) begin
            timeout_status_n <= 1'b1; // [RULE8]
            powerdown_status_n <= 1'b0; // [RULE8]
        end
    end

    // watchdog prescaler and counter, frozen while the oscillator is stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdog_pre_r <= '0;
            watchdog_counter <= '0;
        end else if (exec_sleep || wr_wdog) begin
            wdog_pre_r <= '0; // [RULE7]
            watchdog_counter <= '0; // [RULE7]
        end else if (st_r != rss_pkg::ST_SLEEP) begin
            wdog_pre_r <= wdog_pre_r + 1'b1;
            if (&wdog_pre_r) begin
                watchdog_counter <= watchdog_counter + 1'b1;
            end
        end
    end

    // sleep outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_halt_r <= 1'b0;
            osc_stop_r <= 1'b0;
            wdt_clear_r <= 1'b0;
        end else begin
            wdt_clear_r <= exec_sleep; // [RULE7]
            if (exec_sleep) begin
                core_halt_r <= 1'b1; // [RULE9]
                osc_stop_r <= 1'b1; // [RULE9]
            end else if (st_r == rss_pkg::ST_SLEEP && wake_s2_r) begin
                core_halt_r <= 1'b0;
                osc_stop_r <= 1'b0;
            end
        end
    end

    // last result and retired count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_r <= 8'h00;
            count_r <= 16'h0000;
        end else if (exec) begin
            if (!exec_sleep) begin
                result_r <= alu_res.value;
            end
            count_r <= count_r + 16'h0001;
        end
    end

endmodule

/* tb/rss_chk_properties.sv */
`timescale 1ns/100ps

module rss_chk #(
    parameter int PRE_W = 8,
    parameter int CNT_W = 8
) (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // ready
    input wire logic wake_pin, // wake
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic core_halt, // halted
    input wire logic osc_stop, // osc stop
    input wire logic wdt_clear // wdog clear
);
    logic wr_instr_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_instr_r <= 1'b0;
        end else begin
            wr_instr_r <= hsel && htrans[1] && hready && hwrite && haddr[11:0] == 12'h000;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_resp_okay:
        assert property (hresp == 1'b0) else $error("response not okay");
    chk_ready_high:
        assert property (hresetn && $past(hresetn) |-> hreadyout) else $error("wait state seen");
    chk_unmapped_zero:
        assert property (hsel && htrans[1] && hready && !hwrite && haddr[11:0] == 12'h100
            |=> hrdata == 32'h0) else $error("unmapped read not zero");
    chk_clear_pulse:
        assert property (wdt_clear |=> !wdt_clear) else $error("clear pulse too long");
    chk_clear_entry:
        assert property (wdt_clear |-> core_halt && !$past(core_halt)) else $error("stray clear");
    chk_osc_follow:
        assert property (osc_stop == core_halt) else $error("osc stop differs from halt");
    chk_sleep_enter:
        assert property (wr_instr_r && hwdata[1:0] == 2'h3 && !core_halt
            |-> ##[1:2] (core_halt && wdt_clear)) else $error("sleep not entered");
    chk_halt_hold:
        assert property ((!wake_pin)[*3] ##0 core_halt |=> core_halt) else $error("left sleep");
    chk_wake_exit:
        assert property (core_halt && $rose(wake_pin) |-> ##[2:4] !core_halt)
            else $error("no wake");
endmodule

/* tb/tb.sv */
`timescale 1ns/100ps

module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic wake_pin = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, core_halt, osc_stop, wdt_clear;
    int n_fail = 0;
    int n_tests = 0;
    logic [31:0] q;
    logic [7:0] w_m, f_m, lit, r;
    logic c_m, dcf_m, z_m, dst;
    logic [6:0] fa;
    logic [1:0] op;

    always #20 hclk = ~hclk;

    rss_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .wake_pin(wake_pin), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .core_halt(core_halt), .osc_stop(osc_stop), .wdt_clear(wdt_clear));

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task exec(input logic [1:0] o, input logic de, input logic [6:0] f, input logic [7:0] k);
        bus(1'b1, 32'h0, {8'h00, k, 1'b0, f, 5'h00, de, o});
        repeat (2) @(posedge hclk);
        do bus(1'b0, 32'h8, 32'h0); while (q[5] !== 1'b0 && q[6] !== 1'b1);
    endtask

    // packs {result, carry, digit carry, zero}
    function automatic logic [10:0] alu(input logic [1:0] o, input logic [7:0] v, w, k,
            input logic c, dcf, z);
        logic [7:0] m, d;
        if (o == 2'h0) return {c, v[7:1], v[0], dcf, z};
        m = (o == 2'h1) ? k : v;
        d = m - w;
        return {d, w <= m, w[3:0] <= m[3:0], d == 8'h00};
    endfunction

    initial begin
        q = $urandom(63);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 40; i++) begin
            op = (i < 3) ? i[1:0] : 2'($urandom % 3);
            dst = 1'($urandom);
            fa = 7'($urandom);
            lit = 8'($urandom);
            w_m = 8'($urandom);
            f_m = 8'($urandom);
            {c_m, dcf_m, z_m} = 3'($urandom);
            if (i == 0) {fa, f_m, c_m} = {7'h7F, 8'h01, 1'b1};
            if (i == 1) {lit, w_m, dst} = {8'h00, 8'h01, 1'b1};
            if (i == 2) {fa, f_m, w_m} = {7'h00, 8'h10, 8'h01};
            if (i == 3) {op, lit, w_m} = {2'h1, 8'hFF, 8'hFF};
            bus(1'b1, 32'h200 + {fa, 2'b00}, {24'h0, f_m});
            bus(1'b1, 32'h4, {24'h0, w_m});
            bus(1'b1, 32'h8, {29'h0, z_m, dcf_m, c_m});
            exec(op, dst, fa, lit);
            {r, c_m, dcf_m, z_m} = alu(op, f_m, w_m, lit, c_m, dcf_m, z_m);
            if (op == 2'h1 || !dst) w_m = r;
            else f_m = r;
            bus(1'b0, 32'h4, 32'h0);
            chk(q, {24'h0, w_m});
            bus(1'b0, 32'h200 + {fa, 2'b00}, 32'h0);
            chk(q, {24'h0, f_m});
            bus(1'b0, 32'h8, 32'h0);
            chk(q & 32'h7F, {29'h3, z_m, dcf_m, c_m});
        end
        $display("instruction tests done");
        bus(1'b1, 32'h100, 32'hFFFFFFFF);
        bus(1'b0, 32'h100, 32'h0);
        chk(q, 32'h0);
        $display("unmapped test done");
        {c_m, dcf_m, z_m} = 3'($urandom);
        bus(1'b1, 32'h8, {29'h0, z_m, dcf_m, c_m});
        repeat (20) @(posedge hclk);
        bus(1'b0, 32'hC, 32'h0);
        chk({31'h0, q != 32'h0}, 32'h1);
        exec(2'h3, 1'b0, 7'h00, 8'h00);
        chk({30'h0, core_halt, osc_stop}, 32'h3);
        bus(1'b0, 32'hC, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 32'h8, 32'h0);
        chk(q & 32'h7F, {25'h0, 4'hD, z_m, dcf_m, c_m});
        bus(1'b0, 32'h4, 32'h0);
        chk(q, {24'h0, w_m});
        wake_pin <= 1'b1;
        repeat (6) @(posedge hclk);
        wake_pin <= 1'b0;
        chk({31'h0, core_halt}, 32'h0);
        $display("sleep test done");
        tally_and_finish();
    end

    initial begin
        #(40 * 20000);
        n_fail++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule

bind rss_top rss_chk #(.PRE_W(PRE_W), .CNT_W(CNT_W)) u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .wake_pin(wake_pin), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_halt(core_halt), .osc_stop(osc_stop),
    .wdt_clear(wdt_clear));
